// *** rtl/udie_pkg.sv ***
// constants for the serial port data, divisor and interrupt enable slice
// assumes a 32-bit register port with separate read and write strobes
package udie_pkg;
  localparam logic [3:0]  UDIE_OFS_DATA = 4'h0;
  localparam logic [3:0]  UDIE_OFS_IER  = 4'h4;
  localparam logic [15:0] UDIE_DIV_RESET = 16'h0002;
  localparam int          UDIE_IER_RX_AVAILABLE_INT_ENABLE = 0;
  localparam int          UDIE_IER_TIE   = 1;
  localparam int          UDIE_IER_LINE_STATUS_INT_ENABLE  = 2;
  localparam int          UDIE_IER_MIE   = 3;
  localparam int          UDIE_IER_RX_TIMEOUT_INT_ENABLE = 4;
  localparam int          UDIE_IER_NRZ_CODING_ENABLE  = 5;
  localparam int          UDIE_IER_UUE   = 6;
  localparam int          UDIE_IER_DMA_REQUEST_ENABLE  = 7;
  localparam int          UDIE_IER_HSE   = 8;
  localparam logic [8:0]  UDIE_IER_MASK  = 9'h1ff;
  typedef enum logic [1:0] {
    UDIE_TX_IDLE = 2'b01,
    UDIE_TX_BUSY = 2'b10
  } udie_tx_state_t;
endpackage : udie_pkg

// *** rtl/udie_baud.sv ***
// baud generator: sixteen-times pulse from the divisor
// assumes divisor changes only while the line is idle
`timescale 1ns/1ns
`default_nettype none
module udie_baud
  import udie_pkg::*;
(
  input  wire logic        clk,      // clock
  input  wire logic        rst,      // async reset
  input  wire logic [15:0] divisor,  // divisor value
  output logic             tick16    // sixteen-times pulse
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        tick_ff;
  logic        nxt_tick;
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (divisor == 16'h0000) begin
      nxt_cnt = 16'h0000;
    end else if (cnt_ff + 16'h0001 >= divisor) begin
      nxt_cnt  = 16'h0000;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
  assign tick16 = tick_ff;
  a_zero_stops: assert property (@(posedge clk) disable iff (rst)
    divisor == 16'h0000 |=> !tick16) else $error("tick with zero divisor");
endmodule : udie_baud
`default_nettype wire

// *** rtl/udie_top.sv ***
// register slice: receive buffer, transmit holding, divisor, interrupt enable
// assumes synchronous byte-lane register port; receive FIFO and line status outside
`timescale 1ns/1ns
`default_nettype none
module udie_top
  import udie_pkg::*;
#(
  parameter int TX_DEPTH = 64
) (
  input  wire logic        CLK,          // clock
  input  wire logic        RST,          // async reset
  input  wire logic [3:0]  ADDR,         // byte offset
  input  wire logic        WR,           // write strobe
  input  wire logic        RD,           // read strobe
  input  wire logic [31:0] WDATA,        // write data
  output logic [31:0]      RDATA,        // read data, registered
  input  wire logic        DIV_SEL,      // divisor access select
  input  wire logic        FIFO_MODE,    // fifo enable
  input  wire logic        BUS32_MODE,   // 32-bit bus mode
  input  wire logic        RX_VALID,     // receive byte valid (front)
  input  wire logic [31:0] RX_WORD,      // receive front word
  input  wire logic        RX_FRONT_ERR, // front byte has error
  input  wire logic        RX_FIFO_ERR,  // line status bit 7
  input  wire logic        RX_TRIGGER,   // receive trigger reached
  input  wire logic        RX_TIMEOUT,   // character timeout
  input  wire logic        MODEM_EVT,    // modem status change
  output logic             RX_POP,       // receive buffer read
  output logic             RX_DATA_READY,// data ready flag
  output logic             TX_LOAD,      // shifter load pulse
  output logic [7:0]       TX_BYTE,      // byte to shifter
  input  wire logic        TX_SHIFT_EMPTY,// shifter empty
  output logic             TX_DATA_REQ,  // transmit request flag
  output logic [4:0]       INT_SRC,      // gated sources
  output logic             ERR_INT,      // error interrupt
  output logic             RX_DMA_REQ,   // receive dma request
  output logic             TX_DMA_REQ,   // transmit dma request
  output logic             UNIT_EN,      // unit enable
  output logic             NRZ_EN,       // nrz enable
  output logic             HS_EN,        // high speed enable
  output logic             BAUD_TICK     // sixteen-times pulse
);
  localparam int PW = $clog2(TX_DEPTH);
  // pointer wrap logic needs a power-of-two depth
  if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("TX_DEPTH must be a power of two of at least 2");
  end
  // ****************************************
  // register file
  // ****************************************
  logic [15:0] div_ff, nxt_div;
  logic [8:0]  ier_ff, nxt_ier;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        dr_ff, nxt_dr;
  logic        wr_data, wr_ier, wr_dll, wr_dlh, rd_data;
  always_comb begin
    wr_data = WR && ADDR == UDIE_OFS_DATA && !DIV_SEL;
    wr_ier  = WR && ADDR == UDIE_OFS_IER && !DIV_SEL;
    wr_dll  = WR && ADDR == UDIE_OFS_DATA && DIV_SEL;
    wr_dlh  = WR && ADDR == UDIE_OFS_IER && DIV_SEL;
    rd_data = RD && ADDR == UDIE_OFS_DATA && !DIV_SEL;
    nxt_div = div_ff;
    if (wr_dll) nxt_div[7:0] = WDATA[7:0];
    if (wr_dlh) nxt_div[15:8] = WDATA[7:0];
    nxt_ier = wr_ier ? (WDATA[8:0] & UDIE_IER_MASK) : ier_ff;
    nxt_rdata = rdata_ff;
    if (RD) begin
      nxt_rdata = 32'h0000_0000;
      case (ADDR)
        UDIE_OFS_DATA: begin
          if (DIV_SEL) nxt_rdata[7:0] = div_ff[7:0];
          else if (BUS32_MODE) nxt_rdata = RX_WORD;
          else nxt_rdata[7:0] = RX_WORD[7:0];
        end
        UDIE_OFS_IER: begin
          if (DIV_SEL) nxt_rdata[7:0] = div_ff[15:8];
          else nxt_rdata[8:0] = ier_ff;
        end
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    // in non-fifo mode the read clear wins over a new byte arriving while the flag is set; in fifo mode the flag follows RX_VALID
    nxt_dr = FIFO_MODE ? RX_VALID : ((dr_ff && !rd_data) || (RX_VALID && !dr_ff));
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_ff   <= UDIE_DIV_RESET;
      ier_ff   <= 9'h000;
      rdata_ff <= 32'h0000_0000;
      dr_ff    <= 1'b0;
    end else begin
      div_ff   <= nxt_div;
      ier_ff   <= nxt_ier;
      rdata_ff <= nxt_rdata;
      dr_ff    <= nxt_dr;
    end
  end
  assign RDATA         = rdata_ff;
  assign RX_POP        = rd_data && (FIFO_MODE ? RX_VALID : dr_ff);
  assign RX_DATA_READY = dr_ff;
  assign UNIT_EN       = ier_ff[UDIE_IER_UUE];
  assign NRZ_EN        = ier_ff[UDIE_IER_NRZ_CODING_ENABLE];
  assign HS_EN         = ier_ff[UDIE_IER_HSE];
  // ****************************************
  // transmit holding and fifo
  // ****************************************
  logic [7:0]     mem_ff [TX_DEPTH];
  logic [7:0]     nxt_wbyte;
  logic [PW:0]    wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [7:0]     txb_ff, nxt_txb;
  logic           load_ff, nxt_load;
  udie_tx_state_t st_ff, nxt_st;
  logic           empty, full, reqf;
  always_comb begin
    empty     = wp_ff == rp_ff;
    full      = (wp_ff[PW-1:0] == rp_ff[PW-1:0]) && (wp_ff[PW] != rp_ff[PW]);
    nxt_wp    = wp_ff;
    nxt_rp    = rp_ff;
    nxt_txb   = txb_ff;
    nxt_load  = 1'b0;
    nxt_st    = st_ff;
    nxt_wbyte = WDATA[7:0];
    // non-fifo mode uses one slot as the holding byte
    if (wr_data && !full && (FIFO_MODE || empty)) nxt_wp = wp_ff + 1'b1;
    case (st_ff)
      UDIE_TX_IDLE: begin
        if (!empty && TX_SHIFT_EMPTY) begin
          nxt_txb  = mem_ff[rp_ff[PW-1:0]];
          nxt_rp   = rp_ff + 1'b1;
          nxt_load = 1'b1;
          nxt_st   = UDIE_TX_BUSY;
        end
      end
      UDIE_TX_BUSY: nxt_st = UDIE_TX_IDLE;
      default: nxt_st = UDIE_TX_IDLE;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (nxt_wp != wp_ff) mem_ff[wp_ff[PW-1:0]] <= nxt_wbyte;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wp_ff   <= '0;
      rp_ff   <= '0;
      txb_ff  <= 8'h00;
      load_ff <= 1'b0;
      st_ff   <= UDIE_TX_IDLE;
    end else begin
      wp_ff   <= nxt_wp;
      rp_ff   <= nxt_rp;
      txb_ff  <= nxt_txb;
      load_ff <= nxt_load;
      st_ff   <= nxt_st;
    end
  end
  assign reqf        = FIFO_MODE ? ((wp_ff - rp_ff) <= (PW + 1)'(TX_DEPTH / 2)) : empty;
  assign TX_DATA_REQ = reqf;
  assign TX_LOAD     = load_ff;
  assign TX_BYTE     = txb_ff;
  // ****************************************
  // interrupt gating and dma
  // ****************************************
  logic dma_request_enable;
  assign dma_request_enable = ier_ff[UDIE_IER_DMA_REQUEST_ENABLE];
  assign INT_SRC[0] = ier_ff[UDIE_IER_LINE_STATUS_INT_ENABLE] && RX_FRONT_ERR;
  assign INT_SRC[1] = ier_ff[UDIE_IER_RX_AVAILABLE_INT_ENABLE] && RX_TRIGGER;
  assign INT_SRC[2] = ier_ff[UDIE_IER_RX_TIMEOUT_INT_ENABLE] && RX_TIMEOUT;
  assign INT_SRC[3] = ier_ff[UDIE_IER_TIE] && reqf;
  assign INT_SRC[4] = ier_ff[UDIE_IER_MIE] && MODEM_EVT;
  assign ERR_INT    = dma_request_enable && RX_FIFO_ERR;
  // request returns by itself once the error flag drops with the last errored read
  assign RX_DMA_REQ = dma_request_enable && RX_TRIGGER && !RX_FIFO_ERR;
  assign TX_DMA_REQ = dma_request_enable && reqf;
  // ****************************************
  // baud generator
  // ****************************************
  udie_baud u_baud (
    .clk     (CLK),
    .rst     (RST),
    .divisor (div_ff),
    .tick16  (BAUD_TICK)
  );
  // ****************************************
  // checks
  // ****************************************
  a_err_masked: assert property (@(posedge CLK) disable iff (RST)
    ERR_INT |-> dma_request_enable && RX_FIFO_ERR) else $error("error int without dma");
  a_err_unmask: assert property (@(posedge CLK) disable iff (RST)
    dma_request_enable && RX_FIFO_ERR |-> ERR_INT && !RX_DMA_REQ) else $error("error not raised");
  a_tx_load: assert property (@(posedge CLK) disable iff (RST)
    st_ff == UDIE_TX_IDLE && !empty && TX_SHIFT_EMPTY |=> TX_LOAD) else $error("no load");
  a_ier_write: assert property (@(posedge CLK) disable iff (RST)
    wr_ier |=> ier_ff == $past(WDATA[8:0])) else $error("enable not stored");
  a_div_gated: assert property (@(posedge CLK) disable iff (RST)
    WR && !DIV_SEL |=> $stable(div_ff)) else $error("divisor written without select");
  a_dr_clear: assert property (@(posedge CLK) disable iff (RST)
    !FIFO_MODE && rd_data && dr_ff && !RX_VALID |=> !dr_ff) else $error("dr kept");
  a_rx_narrow: assert property (@(posedge CLK) disable iff (RST)
    rd_data && !BUS32_MODE |=> RDATA[31:8] == 24'h000000) else $error("upper bytes set");
  a_rls_front: assert property (@(posedge CLK) disable iff (RST)
    INT_SRC[0] |-> RX_FRONT_ERR) else $error("rls early");
  c_tx_load: cover property (@(posedge CLK) TX_LOAD);
  c_err_int: cover property (@(posedge CLK) ERR_INT);
  c_rx_read: cover property (@(posedge CLK) RX_POP);
endmodule : udie_top
`default_nettype wire

// *** tb/udie_shifter_model.sv ***
// transmit shifter stand-in at the line side of the slice
// assumes one load pulse per byte and a fixed shift time
`timescale 1ns/1ns
`default_nettype none
module udie_shifter_model #(
  parameter int SHIFT_CYCLES = 20
) (
  input  wire logic       CLK,           // clock
  input  wire logic       RST,           // async reset
  input  wire logic       TX_LOAD,       // load pulse
  input  wire logic [7:0] TX_BYTE,       // byte loaded
  output var  logic       TX_SHIFT_EMPTY // shifter empty
);
  // ****************
  // shift timing
  // ****************
  logic [7:0] got[$];
  int         busy_cnt;
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      busy_cnt <= 0;
      got.delete();
    end else if (TX_LOAD) begin
      got.push_back(TX_BYTE);
      busy_cnt <= SHIFT_CYCLES;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end
  assign TX_SHIFT_EMPTY = (busy_cnt == 0);
endmodule : udie_shifter_model
`default_nettype wire

// *** tb/uart_data_divisor_irq_enable_test.sv ***
// self-checking bench for udie_top
// assumes the shifter model on the transmit side; receive side driven here
`timescale 1ns/1ns
`default_nettype none
module uart_data_divisor_irq_enable_test import udie_pkg::*;;
  logic        CLK, RST, WR, RD, DIV_SEL, FIFO_MODE, BUS32_MODE, RX_VALID;
  logic        RX_FRONT_ERR, RX_FIFO_ERR, RX_TRIGGER, RX_TIMEOUT, MODEM_EVT;
  logic        RX_POP, RX_DATA_READY, TX_LOAD, TX_SHIFT_EMPTY, TX_DATA_REQ;
  logic        ERR_INT, RX_DMA_REQ, TX_DMA_REQ, UNIT_EN, NRZ_EN, HS_EN, BAUD_TICK;
  logic [3:0]  ADDR;
  logic [31:0] WDATA, RDATA, RX_WORD;
  logic [7:0]  TX_BYTE;
  logic [4:0]  INT_SRC;
  int          errors, n_checks, cycles;
  udie_top #(.TX_DEPTH(4)) DUT (.CLK, .RST, .ADDR, .WR, .RD, .WDATA, .RDATA,
    .DIV_SEL, .FIFO_MODE, .BUS32_MODE, .RX_VALID, .RX_WORD, .RX_FRONT_ERR,
    .RX_FIFO_ERR, .RX_TRIGGER, .RX_TIMEOUT, .MODEM_EVT, .RX_POP, .RX_DATA_READY,
    .TX_LOAD, .TX_BYTE, .TX_SHIFT_EMPTY, .TX_DATA_REQ, .INT_SRC, .ERR_INT,
    .RX_DMA_REQ, .TX_DMA_REQ, .UNIT_EN, .NRZ_EN, .HS_EN, .BAUD_TICK);
  udie_shifter_model shifter (.CLK, .RST, .TX_LOAD, .TX_BYTE, .TX_SHIFT_EMPTY);
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      conclude();
    end
  end
  // ****************
  // bus and compare
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [3:0] a, input logic s, input logic [31:0] d);
    @(negedge CLK);
    {ADDR, DIV_SEL, WDATA, WR} = {a, s, d, 1'b1};
    @(negedge CLK);
    WR = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic s, output logic [31:0] d);
    @(negedge CLK);
    {ADDR, DIV_SEL, RD} = {a, s, 1'b1};
    @(negedge CLK);
    RD = 1'b0;
    d = RDATA;
  endtask : rd
  task automatic wait_hi(ref logic sig);
    for (int i = 0; i < 400 && sig !== 1'b1; i++)
      @(negedge CLK);
  endtask : wait_hi
  task automatic drain(input logic [7:0] exp[$]);
    for (int i = 0; i < 400 && shifter.got.size() < exp.size(); i++)
      @(negedge CLK);
    wait_hi(TX_SHIFT_EMPTY);
    repeat (3) @(negedge CLK);
    chk(shifter.got.size(), exp.size());
    foreach (exp[i]) chk(shifter.got[i], exp[i]);
    shifter.got.delete();
  endtask : drain
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    logic [31:0] v;
    rd(UDIE_OFS_IER, 1'b0, v);
    chk(v, 32'h0);
    rd(UDIE_OFS_DATA, 1'b1, v);
    chk(v, {24'h0, UDIE_DIV_RESET[7:0]});
    rd(UDIE_OFS_IER, 1'b1, v);
    chk(v, {24'h0, UDIE_DIV_RESET[15:8]});
    chk(TX_DATA_REQ, 1'b1);
  endtask : t_reset
  task automatic t_tx();
    wr(UDIE_OFS_DATA, 1'b0, 32'h55);
    chk(TX_DATA_REQ, 1'b0);
    wait_hi(TX_DATA_REQ);
    wr(UDIE_OFS_DATA, 1'b0, 32'h66);
    wr(UDIE_OFS_DATA, 1'b0, 32'h77);
    drain({8'h55, 8'h66});
    FIFO_MODE = 1'b1;
    for (int i = 1; i <= 6; i++)
      wr(UDIE_OFS_DATA, 1'b0, 32'h10 * i);
    chk(TX_DATA_REQ, 1'b0);
    drain({8'h10, 8'h20, 8'h30, 8'h40, 8'h50});
  endtask : t_tx
  task automatic t_enable();
    logic [31:0] v;
    int map[5] = '{1, 3, 0, 4, 2};
    wr(UDIE_OFS_IER, 1'b0, 32'h160);
    rd(UDIE_OFS_IER, 1'b0, v);
    chk(v, 32'h160);
    chk({HS_EN, UNIT_EN, NRZ_EN}, 3'b111);
    {RX_VALID, RX_FRONT_ERR, RX_TRIGGER, RX_TIMEOUT, MODEM_EVT} = 5'h1f;
    @(negedge CLK);
    chk(INT_SRC, 5'h0);
    for (int i = 0; i < 5; i++) begin
      wr(UDIE_OFS_IER, 1'b0, 32'h1 << i);
      chk(INT_SRC, 5'h1 << map[i]);
    end
    {RX_FRONT_ERR, RX_TIMEOUT, MODEM_EVT} = 3'h0;
  endtask : t_enable
  task automatic t_dma();
    RX_FIFO_ERR = 1'b1;
    @(negedge CLK);
    chk(ERR_INT, 1'b0);
    wr(UDIE_OFS_IER, 1'b0, 32'h80);
    chk({ERR_INT, RX_DMA_REQ, TX_DMA_REQ}, 3'b101);
    chk(INT_SRC, 5'h0);
    RX_FIFO_ERR = 1'b0;
    @(negedge CLK);
    chk({ERR_INT, RX_DMA_REQ, TX_DMA_REQ}, 3'b011);
    wr(UDIE_OFS_IER, 1'b0, 32'h160);
    chk({RX_DMA_REQ, TX_DMA_REQ}, 2'b00);
    {RX_VALID, RX_TRIGGER, FIFO_MODE} = 3'h0;
  endtask : t_dma
  task automatic t_divisor();
    logic [31:0] v;
    int n;
    wr(UDIE_OFS_IER, 1'b1, 32'h0);
    rd(UDIE_OFS_IER, 1'b1, v);
    chk(v, 32'h0);
    wr(UDIE_OFS_DATA, 1'b1, 32'h3);
    rd(UDIE_OFS_IER, 1'b0, v);
    chk(v, 32'h160);
    wait_hi(BAUD_TICK);
    @(negedge CLK);
    for (n = 1; n < 200 && BAUD_TICK !== 1'b1; n++)
      @(negedge CLK);
    chk(n, 3);
    wr(UDIE_OFS_DATA, 1'b1, 32'h0);
    repeat (2) @(negedge CLK);
    n = 0;
    repeat (40) begin
      @(negedge CLK);
      n += (BAUD_TICK !== 1'b0);
    end
    chk(n, 0);
  endtask : t_divisor
  task automatic t_rx();
    logic [31:0] v;
    // empty the buffer first so that a stale flag cannot pass the set check
    rd(UDIE_OFS_DATA, 1'b0, v);
    chk(RX_DATA_READY, 1'b0);
    {RX_WORD, RX_VALID} = {32'ha5a5_a53c, 1'b1};
    @(negedge CLK);
    RX_VALID = 1'b0;
    @(negedge CLK);
    chk(RX_DATA_READY, 1'b1);
    {ADDR, DIV_SEL, RD} = {UDIE_OFS_DATA, 1'b0, 1'b1};
    #10;
    chk(RX_POP, 1'b1);
    @(negedge CLK);
    RD = 1'b0;
    v = RDATA;
    chk(v, 32'h3c);
    chk(RX_DATA_READY, 1'b0);
    BUS32_MODE = 1'b1;
    RX_VALID = 1'b1;
    @(negedge CLK);
    RX_VALID = 1'b0;
    rd(UDIE_OFS_DATA, 1'b0, v);
    chk(v, 32'ha5a5_a53c);
    chk(RX_DATA_READY, 1'b0);
    BUS32_MODE = 1'b0;
  endtask : t_rx
  initial begin
    RST = 1'b1;
    {WR, RD, ADDR, WDATA, DIV_SEL, FIFO_MODE, BUS32_MODE, RX_VALID, RX_WORD,
     RX_FRONT_ERR, RX_FIFO_ERR, RX_TRIGGER, RX_TIMEOUT, MODEM_EVT} = 0;
    repeat (20) @(negedge CLK);
    RST = 1'b0;
    t_reset();
    t_tx();
    t_enable();
    t_dma();
    t_divisor();
    t_rx();
    conclude();
  end
endmodule : uart_data_divisor_irq_enable_test
`default_nettype wire
